/* logic/fawp_pkg.sv */
package fawp_pkg;
   localparam int unsigned CLK_HZ      = 10_000_000;
   localparam int unsigned POR_WAIT_US = 10;
   localparam int unsigned POR_CYC     = POR_WAIT_US * (CLK_HZ / 1_000_000);
   localparam int unsigned POR_W       = $clog2(POR_CYC + 1);

   localparam int unsigned ARRAY_BYTES = 8388608;
   localparam int unsigned SECTORS     = 128;
   localparam int unsigned SUBSECTORS  = 2048;
   localparam int unsigned PAGE_BYTES  = 256;
   localparam int unsigned OTP_BYTES   = 64;
   localparam int unsigned SEC_W       = 7;
   localparam logic [23:0] TOP_ADDR    = 24'h7F_FFFF;
   localparam logic [23:0] SUB_MASK    = 24'hFF_F000;
   localparam logic [23:0] SEC_MASK    = 24'hFF_0000;
   localparam logic [23:0] PAGE_MASK   = 24'hFF_FF00;
   localparam int unsigned SEC_LSB     = 16;
   localparam int unsigned SUB_LSB     = 12;

   localparam logic [7:0] REG_STATUS = 8'h00;
   localparam logic [7:0] REG_CMD    = 8'h04;
   localparam logic [7:0] REG_ADDR   = 8'h08;
   localparam logic [7:0] REG_RESULT = 8'h0C;
   localparam logic [7:0] REG_LOCK   = 8'h10;
   localparam logic [7:0] REG_DATA   = 8'h14;

   localparam int unsigned ST_POK_BIT   = 0;
   localparam int unsigned ST_WEL_BIT   = 1;
   localparam int unsigned ST_BP_LSB    = 2;
   localparam int unsigned ST_TB_BIT    = 6;
   localparam int unsigned CMD_BP_LSB   = 8;
   localparam int unsigned CMD_TB_BIT   = 12;
   localparam int unsigned CMD_LOCK_BIT = 8;
   localparam int unsigned CMD_LDN_BIT  = 9;
   localparam int unsigned CMD_CNT_LSB  = 16;
   localparam int unsigned RES_DONE_BIT = 0;
   localparam int unsigned RES_OK_BIT   = 1;
   localparam int unsigned RES_WHY_LSB  = 4;
   localparam int unsigned DAT_NEW_LSB  = 8;
   localparam int unsigned DAT_MRG_LSB  = 16;

   localparam logic [3:0] BP_RESET = 4'h0;
   localparam logic       TB_RESET = 1'b0;

   typedef enum logic [3:0] {
      OP_WREN  = 4'h0,
      OP_WRDI  = 4'h1,
      OP_PROG  = 4'h2,
      OP_SSE   = 4'h3,
      OP_SE    = 4'h4,
      OP_BE    = 4'h5,
      OP_WRSR  = 4'h6,
      OP_WRLR  = 4'h7,
      OP_OTP   = 4'h8
   } fawp_op_t;

   typedef enum logic [2:0] {
      WHY_OK    = 3'h0,
      WHY_BADOP = 3'h1,
      WHY_POWER = 3'h2,
      WHY_BITS  = 3'h3,
      WHY_WEL   = 3'h4,
      WHY_ADDR  = 3'h5,
      WHY_PROT  = 3'h6,
      WHY_LDOWN = 3'h7
   } fawp_why_t;
endpackage

/* logic/fawp_prot_if.sv */
`timescale 1ns/1ps
interface fawp_prot_if;
   logic [6:0] sector;
   logic       tb;
   logic [3:0] bp;
   logic       hit;
   logic       any;
   modport chk  (input sector, input tb, input bp, output hit, output any);
   modport user (output sector, output tb, output bp, input hit, input any);
endinterface

/* logic/fawp_range.sv */
`timescale 1ns/1ps
module fawp_range (
   fawp_prot_if.chk p
);
   logic [7:0] span;
   logic [7:0] sec8;

   always_comb begin
      span = 8'h01 << 3'(p.bp[2:0] - 3'h1);
      sec8 = {1'b0, p.sector};
      p.any = (p.bp != 4'h0);
      if (p.bp[3]) begin
         p.hit = 1'b1;
      end else if (p.bp[2:0] == 3'h0) begin
         p.hit = 1'b0;
      end else if (p.tb) begin
         p.hit = (sec8 < span);
      end else begin
         p.hit = (sec8 >= 8'(8'h80 - span));
      end
   end
endmodule

/* logic/fawp_top.sv */
`timescale 1ns/1ps
module fawp_top (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        supply_ok_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   output logic             exec_o,
   output logic      [3:0]  exec_op_o,
   output logic      [23:0] exec_addr_o
);
   localparam int unsigned NS = fawp_pkg::SECTORS;

   logic [fawp_pkg::POR_W-1:0] por_cnt;
   logic                       por_done;
   logic                       power_ok;
   logic                       wel;
   logic [3:0]                 bp;
   logic                       tb;
   logic [23:0]                addr;
   logic [15:0]                data;
   logic                       res_done;
   logic                       res_ok;
   logic [2:0]                 res_why;
   logic [NS-1:0]              wlock;
   logic [NS-1:0]              ldown;

   logic                       req;
   logic                       wr_edge;
   logic                       cmd_go;
   logic [3:0]                 op;
   logic [15:0]                pulses;
   logic [6:0]                 sec;
   logic                       modifying;
   logic                       addressed;
   logic                       addr_bad;
   logic                       prot;
   logic [2:0]                 next_why;
   logic                       accept;
   logic [7:0]                 merged;
   logic [23:0]                next_exec_addr;
   logic [31:0]                next_rd;

   fawp_prot_if pif ();

   fawp_range u_range (
      .p (pif.chk)
   );

   assign pif.sector = sec;
   assign pif.tb     = tb;
   assign pif.bp     = bp;

   assign req     = wb_cyc_i & wb_stb_i;
   assign wr_edge = req & wb_ack_o & wb_we_i & wb_sel_i[0];
   assign cmd_go  = wr_edge & (wb_adr_i == fawp_pkg::REG_CMD);
   assign op      = wb_dat_i[3:0];
   assign pulses  = wb_dat_i[fawp_pkg::CMD_CNT_LSB +: 16];
   assign sec     = addr[fawp_pkg::SEC_LSB +: fawp_pkg::SEC_W];
   assign merged  = data[7:0] & data[fawp_pkg::DAT_NEW_LSB +: 8];
   assign power_ok = por_done & supply_ok_i;

   // Power-up timer: holds off all altering commands after reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         por_cnt  <= '0;
         por_done <= 1'b0;
      end else if (!por_done) begin
         if (por_cnt == fawp_pkg::POR_W'(fawp_pkg::POR_CYC - 1)) begin
            por_done <= 1'b1;
         end
         por_cnt <= por_cnt + fawp_pkg::POR_W'(1);
      end
   end

   always_comb begin
      modifying = 1'b1;
      addressed = 1'b0;
      addr_bad  = 1'b0;
      prot      = 1'b0;
      unique case (op)
         fawp_pkg::OP_WREN, fawp_pkg::OP_WRDI: begin
            modifying = 1'b0;
         end
         fawp_pkg::OP_PROG, fawp_pkg::OP_SSE, fawp_pkg::OP_SE: begin
            addressed = 1'b1;
            addr_bad  = (addr > fawp_pkg::TOP_ADDR);
            prot      = wlock[sec] | pif.hit;
         end
         fawp_pkg::OP_BE: begin
            prot = (|wlock) | pif.any;
         end
         fawp_pkg::OP_OTP: begin
            addressed = 1'b1;
            addr_bad  = (addr >= 24'(fawp_pkg::OTP_BYTES));
         end
         default: begin
         end
      endcase
   end

   always_comb begin
      if (op > fawp_pkg::OP_OTP) begin
         next_why = fawp_pkg::WHY_BADOP;
      end else if (modifying && !power_ok) begin
         next_why = fawp_pkg::WHY_POWER;
      end else if (modifying && pulses[2:0] != 3'h0) begin
         next_why = fawp_pkg::WHY_BITS;
      end else if (modifying && !wel) begin
         next_why = fawp_pkg::WHY_WEL;
      end else if (addressed && addr_bad) begin
         next_why = fawp_pkg::WHY_ADDR;
      end else if (prot) begin
         next_why = fawp_pkg::WHY_PROT;
      end else if (op == fawp_pkg::OP_WRLR && ldown[sec]) begin
         next_why = fawp_pkg::WHY_LDOWN;
      end else begin
         next_why = fawp_pkg::WHY_OK;
      end
   end

   assign accept = cmd_go & (next_why == fawp_pkg::WHY_OK);

   always_comb begin
      unique case (op)
         fawp_pkg::OP_SSE: next_exec_addr = addr & fawp_pkg::SUB_MASK;
         fawp_pkg::OP_SE:  next_exec_addr = addr & fawp_pkg::SEC_MASK;
         fawp_pkg::OP_BE:  next_exec_addr = 24'h00_0000;
         default:          next_exec_addr = addr;
      endcase
   end

   // Write-enable latch
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wel <= 1'b0;
      end else if (cmd_go && op == fawp_pkg::OP_WREN) begin
         wel <= 1'b1;
      end else if (cmd_go && op == fawp_pkg::OP_WRDI) begin
         wel <= 1'b0;
      end else if (accept) begin
         wel <= 1'b0;
      end
   end

   // Block-protect range and top/bottom select
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bp <= fawp_pkg::BP_RESET;
         tb <= fawp_pkg::TB_RESET;
      end else if (accept && op == fawp_pkg::OP_WRSR) begin
         bp <= wb_dat_i[fawp_pkg::CMD_BP_LSB +: 4];
         tb <= wb_dat_i[fawp_pkg::CMD_TB_BIT];
      end
   end

   // Per-sector volatile lock bits
   for (genvar i = 0; i < NS; i++) begin : g_lock
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            wlock[i] <= 1'b0;
            ldown[i] <= 1'b0;
         end else if (accept && op == fawp_pkg::OP_WRLR && sec == 7'(i)) begin
            wlock[i] <= wb_dat_i[fawp_pkg::CMD_LOCK_BIT];
            ldown[i] <= wb_dat_i[fawp_pkg::CMD_LDN_BIT];
         end
      end
   end

   // Address and data holding registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         addr <= 24'h00_0000;
         data <= 16'h0000;
      end else if (wr_edge && wb_adr_i == fawp_pkg::REG_ADDR) begin
         addr <= wb_dat_i[23:0];
      end else if (wr_edge && wb_adr_i == fawp_pkg::REG_DATA) begin
         data <= wb_dat_i[15:0];
      end
   end

   // Verdict of the last command
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         res_done <= 1'b0;
         res_ok   <= 1'b0;
         res_why  <= fawp_pkg::WHY_OK;
      end else if (cmd_go) begin
         res_done <= 1'b1;
         res_ok   <= (next_why == fawp_pkg::WHY_OK);
         res_why  <= next_why;
      end
   end

   // Go pulse to the array engine; rejected commands never reach it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         exec_o      <= 1'b0;
         exec_op_o   <= 4'h0;
         exec_addr_o <= 24'h00_0000;
      end else begin
         exec_o <= accept & modifying & (op != fawp_pkg::OP_WRSR) & (op != fawp_pkg::OP_WRLR);
         if (accept) begin
            exec_op_o   <= op;
            exec_addr_o <= next_exec_addr;
         end
      end
   end

   always_comb begin
      next_rd = 32'h0000_0000;
      unique case (wb_adr_i)
         fawp_pkg::REG_STATUS: begin
            next_rd[fawp_pkg::ST_POK_BIT]    = power_ok;
            next_rd[fawp_pkg::ST_WEL_BIT]    = wel;
            next_rd[fawp_pkg::ST_BP_LSB +: 4] = bp;
            next_rd[fawp_pkg::ST_TB_BIT]     = tb;
         end
         fawp_pkg::REG_ADDR: begin
            next_rd[23:0] = addr;
         end
         fawp_pkg::REG_RESULT: begin
            next_rd[fawp_pkg::RES_DONE_BIT]    = res_done;
            next_rd[fawp_pkg::RES_OK_BIT]      = res_ok;
            next_rd[fawp_pkg::RES_WHY_LSB +: 3] = res_why;
         end
         fawp_pkg::REG_LOCK: begin
            next_rd[1:0] = {ldown[sec], wlock[sec]};
         end
         fawp_pkg::REG_DATA: begin
            next_rd[15:0]                      = data;
            next_rd[fawp_pkg::DAT_MRG_LSB +: 8] = merged;
         end
         default: begin
         end
      endcase
   end

   // Wishbone slave: one wait state, ack for every address
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= req & ~wb_ack_o;
         if (req && !wb_ack_o) begin
            wb_dat_o <= next_rd;
         end
      end
   end
endmodule

/* bench/fawp_top_chk.sv */
`timescale 1ns/1ps
module fawp_top_chk (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic        wb_ack_o,
   input wire logic        exec_o,
   input wire logic [3:0]  exec_op_o,
   input wire logic [23:0] exec_addr_o
);
   logic [7:0] up_cnt;
   // Cycles since reset release, saturating
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         up_cnt <= 8'h00;
      end else if (up_cnt != 8'hFF) begin
         up_cnt <= up_cnt + 8'h01;
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
      else $error("ack not a single cycle after request");
   exec_cause_a:
      assert property (exec_o |-> $past(wb_ack_o && wb_we_i && wb_adr_i == 8'h04 && wb_sel_i[0]))
      else $error("exec without command write");
   exec_kind_a: assert property (exec_o |-> exec_op_o inside {4'h2, 4'h3, 4'h4, 4'h5, 4'h8})
      else $error("exec of a non array opcode");
   sub_align_a: assert property (exec_o && exec_op_o == 4'h3 |-> exec_addr_o[11:0] == 12'h000)
      else $error("subsector erase not aligned");
   sec_align_a: assert property (exec_o && exec_op_o == 4'h4 |-> exec_addr_o[15:0] == 16'h0000)
      else $error("sector erase not aligned");
   array_top_a: assert property (exec_o && exec_op_o < 4'h5 |-> exec_addr_o <= 24'h7FFFFF)
      else $error("exec beyond array top");
   otp_range_a: assert property (exec_o && exec_op_o == 4'h8 |-> exec_addr_o < 24'h000040)
      else $error("otp exec beyond area");
   power_wait_a: assert property (exec_o |-> up_cnt >= 8'h64)
      else $error("exec before power up wait");
   reset_clear_a: assert property ($fell(rst_i) |-> !exec_o && !wb_ack_o && exec_addr_o == 24'h0)
      else $error("outputs not cleared by reset");
endmodule

/* bench/fawp_host.sv */
`timescale 1ns/1ps
module fawp_host (
   input  wire logic        clk_i,
   input  wire logic        ack_i,
   input  wire logic [31:0] dat_i,
   output logic             cyc_o,
   output logic             stb_o,
   output logic             we_o,
   output logic      [7:0]  adr_o,
   output logic      [3:0]  sel_o,
   output logic      [31:0] dat_o
);
   initial begin
      cyc_o = 1'b0;
      stb_o = 1'b0;
      we_o = 1'b0;
      adr_o = 8'h00;
      sel_o = 4'hF;
      dat_o = 32'h0;
   end
   // Classic single cycle; request held until ack is sampled
   task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd, output logic [31:0] rd);
      int n;
      @(posedge clk_i);
      cyc_o <= 1'b1;
      stb_o <= 1'b1;
      we_o <= we;
      adr_o <= adr;
      dat_o <= wd;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_i !== 1'b1 && n < 50);
      rd = dat_i;
      cyc_o <= 1'b0;
      stb_o <= 1'b0;
      if (ack_i !== 1'b1) begin
         fawp_top_tb.fails++;
         fawp_top_tb.complete_run();
      end
   endtask
endmodule

/* bench/fawp_top_tb.sv */
`timescale 1ns/1ps
bind fawp_top fawp_top_chk i_fawp_top_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
   .wb_ack_o(wb_ack_o), .exec_o(exec_o), .exec_op_o(exec_op_o), .exec_addr_o(exec_addr_o));
module fawp_top_tb;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        supply_ok_i = 1'b1;
   logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, exec_o;
   logic [7:0]  wb_adr_i;
   logic [3:0]  wb_sel_i, exec_op_o;
   logic [31:0] wb_dat_i, wb_dat_o, rd, d;
   logic [23:0] exec_addr_o;
   int          fails, checks, wel, bp, tsel, pwr, nexec;
   int          wl[128], ld[128];
   int          probe[6] = '{0, 1, 63, 64, 126, 127};
   always #50 clk_i = ~clk_i;
   always @(posedge clk_i) if (exec_o === 1'b1) nexec <= nexec + 1;
   fawp_top i_fawp_top (.clk_i(clk_i), .rst_i(rst_i), .supply_ok_i(supply_ok_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .exec_o(exec_o), .exec_op_o(exec_op_o), .exec_addr_o(exec_addr_o));
   fawp_host i_fawp_host (.clk_i(clk_i), .ack_i(wb_ack_o), .dat_i(wb_dat_o), .cyc_o(wb_cyc_i), .stb_o(wb_stb_i),
      .we_o(wb_we_i), .adr_o(wb_adr_i), .sel_o(wb_sel_i), .dat_o(wb_dat_i));
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic complete_run();
      $display("checks=%0d fails=%0d", checks, fails);
      if (fails == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic do_reset();
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      {wel, bp, tsel, pwr} = '0;
      foreach (wl[i]) {wl[i], ld[i]} = '0;
   endtask
   function automatic int prot(int s);
      if (bp >= 8) return 1;
      if (bp == 0) return 0;
      return tsel ? (s < (1 << (bp - 1))) : (s >= 128 - (1 << (bp - 1)));
   endfunction
   task automatic cmd(int op, int adr, int cnt, int x);
      int s, w, e, any, xe;
      s = (adr >> 16) & 127;
      any = 0;
      foreach (wl[i]) any |= wl[i];
      if (op > 8) w = 1;
      else if (op < 2) w = 0;
      else if (!pwr) w = 2;
      else if (cnt % 8) w = 3;
      else if (!wel) w = 4;
      else if ((op inside {[2:4]} && adr > 'h7FFFFF) || (op == 8 && adr >= 64)) w = 5;
      else if ((op inside {[2:4]} && (wl[s] || prot(s))) || (op == 5 && (any || bp))) w = 6;
      else if (op == 7 && ld[s]) w = 7;
      else w = 0;
      xe = (w == 0 && op inside {2, 3, 4, 5, 8});
      i_fawp_host.xfer(1'b1, fawp_pkg::REG_ADDR, 32'(adr), rd);
      e = nexec;
      i_fawp_host.xfer(1'b1, fawp_pkg::REG_CMD, {cnt[15:0], 3'b0, x[4:0], 4'b0, op[3:0]}, rd);
      i_fawp_host.xfer(1'b0, fawp_pkg::REG_RESULT, 32'h0, rd);
      check(rd, 32'((w << 4) | ((w == 0) << 1) | 1));
      check(32'(nexec - e), 32'(xe));
      if (xe) check({8'h00, exec_addr_o}, 32'(op == 3 ? adr & 'hFFF000 : op == 4 ? adr & 'hFF0000 :
         op == 5 ? 0 : adr));
      if (xe) check({28'h0, exec_op_o}, 32'(op));
      if (w == 0 && op < 2) wel = (op == 0);
      else if (w == 0) wel = 0;
      if (w == 0 && op == 6) {tsel, bp} = {x >> 4, x & 15};
      if (w == 0 && op == 7) {wl[s], ld[s]} = {x & 1, (x >> 1) & 1};
   endtask
   task automatic mcmd(int op, int adr, int x);
      cmd(0, 0, 8, 0);
      cmd(op, adr, 8, x);
   endtask
   initial begin
      void'($urandom(32'hBDA4A3C5));
      do_reset();
      i_fawp_host.xfer(1'b0, fawp_pkg::REG_STATUS, 32'h0, rd);
      check(rd, 32'h0);
      mcmd(2, 0, 0);
      repeat (110) @(posedge clk_i);
      pwr = 1;
      cmd(1, 0, 8, 0);
      cmd(2, 0, 8, 0);
      cmd(0, 0, 8, 0);
      cmd(2, 0, 9, 0);
      for (int op = 9; op < 16; op++) cmd(op, 0, 8, 0);
      mcmd(2, 'h800000, 0);
      mcmd(8, 64, 0);
      mcmd(8, 63, 0);
      mcmd(3, $urandom & 'h7FFFFF, 0);
      repeat (4) begin
         d = $urandom;
         i_fawp_host.xfer(1'b1, fawp_pkg::REG_DATA, d, rd);
         i_fawp_host.xfer(1'b0, fawp_pkg::REG_DATA, 32'h0, rd);
         check(rd, {8'h00, d[7:0] & d[15:8], d[15:0]});
      end
      for (int t = 0; t < 2; t++) for (int b = 0; b < 10; b++) begin
         mcmd(6, 0, (t << 4) | (b == 9 ? 15 : b));
         i_fawp_host.xfer(1'b0, fawp_pkg::REG_STATUS, 32'h0, rd);
         check(rd, 32'((tsel << 6) | (bp << 2) | 1));
         foreach (probe[i]) mcmd(4, (probe[i] << 16) | ($urandom & 'hFFFF), 0);
      end
      mcmd(6, 0, 0);
      mcmd(7, 'h50000, 1);
      mcmd(4, 'h50000, 0);
      mcmd(5, 0, 0);
      mcmd(7, 'h50000, 0);
      mcmd(2, 'h51234, 0);
      mcmd(7, 'h50000, 3);
      mcmd(7, 'h50000, 0);
      i_fawp_host.xfer(1'b0, fawp_pkg::REG_LOCK, 32'h0, rd);
      check(rd, 32'h3);
      @(posedge clk_i);
      supply_ok_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      pwr = 0;
      mcmd(2, 0, 0);
      supply_ok_i <= 1'b1;
      do_reset();
      i_fawp_host.xfer(1'b1, fawp_pkg::REG_ADDR, 32'h50000, rd);
      i_fawp_host.xfer(1'b0, fawp_pkg::REG_LOCK, 32'h0, rd);
      check(rd, 32'h0);
      complete_run();
   end
endmodule
